// file: tb/ltv_ee_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// serial eeprom behind the product-data engine
// ****************************************
module ltv_ee_model (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic req_in,
	input wire logic write_in,
	input wire logic [8:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [7:0] delay_in,
	output logic done_out,
	output logic [31:0] rdata_out
);
	logic [7:0] mem [0:511];
	logic [7:0] cnt_ff;
	// delay_in picks a prompt or a slow eeprom; data toggles outside the done cycle of a read
	always_ff @(posedge mclk_in) begin
		done_out <= 1'b0;
		rdata_out <= srst_in ? 32'h0 : ~rdata_out;
		if (srst_in) begin
			for (int i = 0; i < 512; i++) begin
				mem[i] <= 8'(i) ^ 8'h5a;
			end
		end
		if (srst_in || !req_in || done_out) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff == delay_in) begin
			done_out <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				if (write_in) begin
					mem[addr_in + 9'(i)] <= wdata_in[8*i +: 8];
				end else begin
					rdata_out[8*i +: 8] <= mem[addr_in + 9'(i)];
				end
			end
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltv_regs.svh"
module testbench;
	import ltv_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;
		ltv_resp_t r;} ltv_row_t;
	logic mclk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, ee_wd, ee_rd, fast_training_set, d;
	logic [3:0] wstrb = 4'h0;
	logic [7:0] ee_dly = 8'd40, receiver_clock_recovery;
	logic [6:0] l0s, l1;
	logic [8:0] ee_addr, wms;
	logic awready, wready, bvalid, arready, rvalid, ee_req, ee_wr, ee_done, irq;
	ltv_resp_t bresp, rresp, r;
	int failures = 0, tests_run = 0;
	ltv_row_t rows[10];
	logic [7:0] wsel[4] = '{8'h00, 8'h01, 8'h80, 8'hff};
	logic [8:0] wexp[4] = '{9'd128, 9'd129, 9'd0, 9'd127};
	ltv_link_timing_regs uut (.mclk_in(mclk), .srst_in(srst), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .ee_req_out(ee_req), .ee_write_out(ee_wr),
		.ee_byte_addr_out(ee_addr), .ee_wdata_out(ee_wd), .ee_done_in(ee_done),
		.ee_rdata_in(ee_rd), .cdr_fts_count_out(receiver_clock_recovery), .fts_set_symbols_out(fast_training_set),
		.l0s_exit_latency_out(l0s), .l1_exit_latency_out(l1), .l1_entry_wait_ms_out(wms),
		.irq_out(irq));
	ltv_ee_model ee_model (.mclk_in(mclk), .srst_in(srst), .req_in(ee_req), .write_in(ee_wr),
		.addr_in(ee_addr), .wdata_in(ee_wd), .delay_in(ee_dly), .done_out(ee_done),
		.rdata_out(ee_rd));
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// ****************************************
	// bus master: ready sampled at negedge, acted on at the next rising edge
	// ****************************************
	task automatic axw(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
		logic ah, wh, bh;
		@(posedge mclk);
		awaddr <= a;
		wdata <= dd;
		wstrb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		ah = 1'b1;
		wh = 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge mclk);
			ah = ah && !awready;
			wh = wh && !wready;
			bh = bvalid;
			r = bresp;
			@(posedge mclk);
			awv <= ah;
			wv <= wh;
		end
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a);
		logic h;
		@(posedge mclk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		h = 1'b0;
		while (!h) begin
			@(negedge mclk);
			h = arready;
			@(posedge mclk);
		end
		arv <= 1'b0;
		h = 1'b0;
		while (!h) begin
			@(negedge mclk);
			h = rvalid;
			d = rdata;
			r = rresp;
			@(posedge mclk);
		end
		rready <= 1'b0;
	endtask
	task automatic poll(input logic v);
		int n;
		n = 0;
		do begin
			axr(`LTV_OFF_PD_CTRL);
			n++;
		end while (d[31] !== v && n < 200);
		chk(32'(d[31]), 32'(v));
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		summarize();
	end
	initial begin
		rows = '{'{12'h0d4, 32'hffffffff, 4'hf, 32'hff7f7fff, LTV_RESP_OKAY},
			'{12'h0d4, 32'h12345678, 4'h1, 32'hff7f7f78, LTV_RESP_OKAY},
			'{12'h0dc, 32'ha5a5a5a5, 4'hf, 32'ha5a5a5a5, LTV_RESP_OKAY},
			'{12'h0dc, 32'h00003c00, 4'h2, 32'ha5a53ca5, LTV_RESP_OKAY},
			'{12'h0d8, 32'h00ff0000, 4'h4, 32'h00fcf003, LTV_RESP_OKAY},
			'{12'h0e0, 32'hffffffff, 4'hf, 32'h0, LTV_RESP_OKAY},
			'{12'h0ec, 32'hffffffff, 4'hf, 32'h0, LTV_RESP_OKAY},
			'{12'h0f0, 32'hffffffff, 4'hf, 32'h00000005, LTV_RESP_OKAY},
			'{12'h100, 32'hffffffff, 4'hf, 32'h0, LTV_RESP_SLVERR},
			'{12'h008, 32'hffffffff, 4'hf, 32'h0, LTV_RESP_OKAY}};
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			axw(rows[i].a, rows[i].d, rows[i].s);
			chk(32'(r), 32'(rows[i].r));
			axr(rows[i].a);
			chk(d, rows[i].e);
			chk(32'(r), 32'(rows[i].r));
		end
		chk({receiver_clock_recovery, 1'b0, l0s, 1'b0, l1, 8'h0}, 32'h787f7f00);
		chk(fast_training_set, {{3{`LTV_SYM_K28_1}}, `LTV_SYM_K28_5});
		for (int i = 0; i < 4; i++) begin
			axw(`LTV_OFF_LINK_CFG, {wsel[i], 24'h0}, 4'h8);
			repeat (2) @(negedge mclk);
			chk(32'(wms), 32'(wexp[i]));
		end
		// slow eeprom write, with a start attempt while still busy
		axw(`LTV_OFF_PD_DATA, 32'hdeadbeef, 4'hf);
		axw(`LTV_OFF_PD_CTRL, 32'h80140000, 4'hc);
		@(negedge mclk);
		chk({ee_req, ee_wr, 21'h0, ee_addr}, {2'b11, 21'h0, 9'h054});
		chk(ee_wd, 32'hdeadbeef);
		axw(`LTV_OFF_PD_CTRL, 32'h00240000, 4'hc);
		axr(`LTV_OFF_PD_CTRL);
		chk(d, 32'h8014f003);
		poll(1'b0);
		chk(32'(ee_model.mem[9'h054]), 32'h000000ef);
		axr(`LTV_OFF_IRQ_STATUS);
		chk(d, 32'h2);
		chk(32'(irq), 32'h0);
		axw(`LTV_OFF_IRQ_ENABLE, 32'h3, 4'hf);
		@(negedge mclk);
		chk(32'(irq), 32'h1);
		axw(`LTV_OFF_IRQ_CLEAR, 32'h2, 4'hf);
		@(negedge mclk);
		chk(32'(irq), 32'h0);
		// slow read back of the same word, then a prompt read elsewhere
		axw(`LTV_OFF_PD_DATA, 32'h0, 4'hf);
		axw(`LTV_OFF_PD_CTRL, 32'h00140000, 4'hc);
		axr(`LTV_OFF_PD_CTRL);
		chk(d, 32'h0014f003);
		poll(1'b1);
		axr(`LTV_OFF_PD_DATA);
		chk(d, 32'hdeadbeef);
		chk(32'(irq), 32'h1);
		ee_dly <= 8'd0;
		axw(`LTV_OFF_PD_CTRL, 32'h0, 4'hc);
		poll(1'b1);
		axr(`LTV_OFF_PD_DATA);
		chk(d, 32'h19181b1a);
		// second reset in mid-run
		srst <= 1'b1;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		axr(`LTV_OFF_LINK_CFG);
		chk(d, 32'h00190254);
		axr(`LTV_OFF_PD_CTRL);
		chk(d, 32'h0000f003);
		axr(`LTV_OFF_PD_DATA);
		chk(d, 32'h0);
		chk({irq, 22'h0, wms}, 32'd128);
		summarize();
	end
endmodule
`default_nettype wire

// file: verilog/ltv_link_timing_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltv_regs.svh"
module ltv_link_timing_regs (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output ltv_pkg::ltv_resp_t s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output ltv_pkg::ltv_resp_t s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic ee_req_out,
	output logic ee_write_out,
	output logic [8:0] ee_byte_addr_out,
	output logic [31:0] ee_wdata_out,
	input wire logic ee_done_in,
	input wire logic [31:0] ee_rdata_in,
	output logic [7:0] cdr_fts_count_out,
	output logic [31:0] fts_set_symbols_out,
	output logic [6:0] l0s_exit_latency_out,
	output logic [6:0] l1_exit_latency_out,
	output logic [8:0] l1_entry_wait_ms_out,
	output logic irq_out
);
	import ltv_pkg::*;

	// ****************************************
	// write channel capture
	// ****************************************
	logic aw_have_ff;
	logic w_have_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	ltv_resp_t bresp_ff;
	logic wr_fire;

	assign s_axi_awready_out = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready_out = !w_have_ff && !bvalid_ff;
	assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out = bresp_ff;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			aw_have_ff <= 1'b0;
			awaddr_ff <= 12'h000;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_have_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr_in;
		end else if (wr_fire) begin
			aw_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			w_have_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_have_ff <= 1'b1;
			wdata_ff <= s_axi_wdata_in;
			wstrb_ff <= s_axi_wstrb_in;
		end else if (wr_fire) begin
			w_have_ff <= 1'b0;
		end
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		logic hit;
		hit = (a == `LTV_OFF_LINK_CFG) || (a == `LTV_OFF_PD_CTRL) ||
			(a == `LTV_OFF_PD_DATA) || (a == `LTV_OFF_MSI_CAP) ||
			(a == `LTV_OFF_IRQ_STATUS) || (a == `LTV_OFF_IRQ_ENABLE) ||
			(a == `LTV_OFF_IRQ_CLEAR) ||
			((a >= `LTV_OFF_RSV_LO) && (a <= `LTV_OFF_RSV_HI) && (a[1:0] == 2'h0));
		return hit;
	endfunction

	logic wr_link;
	logic wr_ctrl;
	logic wr_data;
	assign wr_link = wr_fire && (awaddr_ff == `LTV_OFF_LINK_CFG);
	assign wr_ctrl = wr_fire && (awaddr_ff == `LTV_OFF_PD_CTRL);
	assign wr_data = wr_fire && (awaddr_ff == `LTV_OFF_PD_DATA);

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= LTV_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= is_mapped(awaddr_ff) ? LTV_RESP_OKAY : LTV_RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// link timing fields
	// ****************************************
	logic [7:0] cdr_time_ff;
	logic [6:0] l0s_exit_ff;
	logic [6:0] l1_exit_ff;
	logic [7:0] l1_wait_ff;
	logic [31:0] link_merged;
	assign link_merged = merge_bytes({l1_wait_ff, 1'b0, l1_exit_ff, 1'b0, l0s_exit_ff,
		cdr_time_ff}, wdata_ff, wstrb_ff);

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cdr_time_ff <= `LTV_RST_CDR_TIME;
			l0s_exit_ff <= `LTV_RST_L0S_EXIT;
			l1_exit_ff <= `LTV_RST_L1_EXIT;
			l1_wait_ff <= `LTV_RST_L1_WAIT;
		end else if (wr_link) begin
			cdr_time_ff <= link_merged[7:0];
			l0s_exit_ff <= link_merged[`LTV_F_L0S_LSB +: 7];
			l1_exit_ff <= link_merged[`LTV_F_L1_LSB +: 7];
			l1_wait_ff <= link_merged[`LTV_F_WAIT_LSB +: 8];
		end
	end

	// values at or above the half point count from zero, the rest from 128 ms
	logic [8:0] nxt_wait_ms;
	always_comb begin
		if (l1_wait_ff >= `LTV_WAIT_HALF) begin
			nxt_wait_ms = {2'b00, l1_wait_ff[6:0]};
		end else begin
			nxt_wait_ms = `LTV_WAIT_OFFSET_MS + {2'b00, l1_wait_ff[6:0]};
		end
	end

	logic [8:0] wait_ms_ff;
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			wait_ms_ff <= `LTV_WAIT_OFFSET_MS;
		end else begin
			wait_ms_ff <= nxt_wait_ms;
		end
	end

	assign cdr_fts_count_out = cdr_time_ff;
	assign l0s_exit_latency_out = l0s_exit_ff;
	assign l1_exit_latency_out = l1_exit_ff;
	assign l1_entry_wait_ms_out = wait_ms_ff;
	// comma goes first on the wire, so it sits in the low byte
	assign fts_set_symbols_out = {`LTV_SYM_K28_1, `LTV_SYM_K28_1, `LTV_SYM_K28_1,
		`LTV_SYM_K28_5};

	// ****************************************
	// product-data engine control
	// ****************************************
	ltv_state_t state_ff;
	logic pd_flag_ff;
	logic op_write_ff;
	logic [5:0] pd_addr_ff;
	logic [31:0] pd_data_ff;
	logic pd_start;
	logic pd_done;
	// a start while busy is dropped so the pending address and data stay put
	assign pd_start = wr_ctrl && wstrb_ff[3] && (state_ff == LTV_IDLE);
	assign pd_done = (state_ff == LTV_BUSY) && ee_done_in;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_ff <= LTV_IDLE;
			op_write_ff <= 1'b0;
		end else begin
			case (state_ff)
				LTV_IDLE: begin
					if (pd_start) begin
						state_ff <= LTV_BUSY;
						op_write_ff <= wdata_ff[`LTV_F_PD_FLAG];
					end
				end
				LTV_BUSY: begin
					if (ee_done_in) begin
						state_ff <= LTV_IDLE;
					end
				end
				default: begin
					state_ff <= LTV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pd_flag_ff <= 1'b0;
		end else if (pd_start) begin
			pd_flag_ff <= wdata_ff[`LTV_F_PD_FLAG];
		end else if (pd_done) begin
			pd_flag_ff <= !op_write_ff;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pd_addr_ff <= `LTV_RST_PD_ADDR;
		end else if (wr_ctrl && wstrb_ff[2] && (state_ff == LTV_IDLE)) begin
			pd_addr_ff <= wdata_ff[`LTV_F_PD_ADDR_LSB +: 6];
		end
	end

	// read data from the engine wins over a software write in the same cycle
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pd_data_ff <= `LTV_RST_PD_DATA;
		end else if (pd_done && !op_write_ff) begin
			pd_data_ff <= ee_rdata_in;
		end else if (wr_data) begin
			pd_data_ff <= merge_bytes(pd_data_ff, wdata_ff, wstrb_ff);
		end
	end

	// loaded with the field itself, so the first request cycle already carries it
	logic [8:0] ee_addr_ff;
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			ee_addr_ff <= `LTV_PD_EE_BASE;
		end else if (wr_ctrl && wstrb_ff[2] && (state_ff == LTV_IDLE)) begin
			ee_addr_ff <= `LTV_PD_EE_BASE + {1'b0, wdata_ff[`LTV_F_PD_ADDR_LSB +: 6], 2'b00};
		end
	end

	assign ee_req_out = (state_ff == LTV_BUSY);
	assign ee_write_out = op_write_ff;
	assign ee_byte_addr_out = ee_addr_ff;
	assign ee_wdata_out = pd_data_ff;

	// ****************************************
	// interrupt status, enable, clear
	// ****************************************
	logic [1:0] irq_status_ff;
	logic [1:0] irq_enable_ff;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	assign irq_set = {pd_done && op_write_ff, pd_done && !op_write_ff};
	assign irq_clr = (wr_fire && (awaddr_ff == `LTV_OFF_IRQ_CLEAR) && wstrb_ff[0]) ?
		wdata_ff[1:0] : 2'b00;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			irq_status_ff <= 2'b00;
		end else begin
			irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			irq_enable_ff <= 2'b00;
		end else if (wr_fire && (awaddr_ff == `LTV_OFF_IRQ_ENABLE) && wstrb_ff[0]) begin
			irq_enable_ff <= wdata_ff[1:0];
		end
	end

	assign irq_out = |(irq_status_ff & irq_enable_ff);

	// ****************************************
	// read channel
	// ****************************************
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	ltv_resp_t rresp_ff;
	logic [31:0] nxt_rdata;
	assign s_axi_arready_out = !rvalid_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rdata_out = rdata_ff;
	assign s_axi_rresp_out = rresp_ff;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (s_axi_araddr_in)
			`LTV_OFF_LINK_CFG: nxt_rdata = {l1_wait_ff, 1'b0, l1_exit_ff, 1'b0, l0s_exit_ff,
				cdr_time_ff};
			`LTV_OFF_PD_CTRL: nxt_rdata = {pd_flag_ff, 7'h00, pd_addr_ff, 2'b00,
				`LTV_PD_NEXT_PTR, `LTV_PD_CAP_ID};
			`LTV_OFF_PD_DATA: nxt_rdata = pd_data_ff;
			`LTV_OFF_MSI_CAP: nxt_rdata = {16'h0000, `LTV_MSI_NEXT_PTR,
				`LTV_MSI_CAP_ID};
			`LTV_OFF_IRQ_STATUS: nxt_rdata = {30'h0000_0000, irq_status_ff};
			`LTV_OFF_IRQ_ENABLE: nxt_rdata = {30'h0000_0000, irq_enable_ff};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= LTV_RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= is_mapped(s_axi_araddr_in) ? LTV_RESP_OKAY : LTV_RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	cdr_reset_a: assert property (@(posedge mclk_in) srst_in |=>
		(cdr_time_ff == 8'h54) && (l0s_exit_ff == 7'h02) && (l1_exit_ff == 7'h19))
		else $error("link timing fields wrong after reset");
	fts_symbols_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		fts_set_symbols_out == 32'h3c3c_3cbc)
		else $error("fast training set symbols wrong");
	wait_decode_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		##1 (wait_ms_ff == (($past(l1_wait_ff) >= 8'h80) ? {2'b00, $past(l1_wait_ff[6:0])} :
		9'd128 + {2'b00, $past(l1_wait_ff[6:0])})))
		else $error("wait period decode wrong");
	pd_header_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in == 12'h0d8)) |=>
		(s_axi_rdata_out[15:0] == 16'hf003) && s_axi_rvalid_out)
		else $error("product-data header read wrong");
	msi_header_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in == 12'h0f0)) |=>
		(s_axi_rdata_out == 32'h0000_0005))
		else $error("interrupt capability header read wrong");
	rsv_read_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in >= 12'h0e0) &&
		(s_axi_araddr_in <= 12'h0ec)) |=> (s_axi_rdata_out == 32'h0000_0000))
		else $error("reserved range read not zero");
	read_flag_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(ee_req_out && !ee_write_out) |-> !pd_flag_ff)
		else $error("read flag not low while busy");
	read_done_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(pd_done && !op_write_ff) |=> pd_flag_ff && (pd_data_ff == $past(ee_rdata_in))
		&& irq_status_ff[0])
		else $error("read completion not reported");
	write_done_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(pd_done && op_write_ff) |=> !pd_flag_ff && !ee_req_out && irq_status_ff[1])
		else $error("write completion not reported");
	ee_addr_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		ee_req_out |-> (ee_byte_addr_out == 9'h040 + {1'b0, pd_addr_ff, 2'b00}))
		else $error("eeprom address not offset by 40h");
	bresp_time_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		wr_fire |=> s_axi_bvalid_out)
		else $error("write response late");
endmodule
`default_nettype wire

// file: verilog/ltv_pkg.sv
`default_nettype none
package ltv_pkg;
	typedef enum logic [0:0] {
		LTV_IDLE = 1'b0,
		LTV_BUSY = 1'b1
	} ltv_state_t;
	typedef logic [1:0] ltv_resp_t;
	localparam ltv_resp_t LTV_RESP_OKAY = 2'h0;
	localparam ltv_resp_t LTV_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: verilog/ltv_regs.svh
`ifndef LTV_REGS_SVH
`define LTV_REGS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define LTV_OFF_LINK_CFG 12'h0d4
`define LTV_OFF_PD_CTRL 12'h0d8
`define LTV_OFF_PD_DATA 12'h0dc
`define LTV_OFF_RSV_LO 12'h0e0
`define LTV_OFF_RSV_HI 12'h0ec
`define LTV_OFF_MSI_CAP 12'h0f0
`define LTV_OFF_IRQ_STATUS 12'h000
`define LTV_OFF_IRQ_ENABLE 12'h004
`define LTV_OFF_IRQ_CLEAR 12'h008
// ****************************************
// reset values
// ****************************************
`define LTV_RST_CDR_TIME 8'h54
`define LTV_RST_L0S_EXIT 7'h02
`define LTV_RST_L1_EXIT 7'h19
`define LTV_RST_L1_WAIT 8'h00
`define LTV_RST_PD_ADDR 6'h00
`define LTV_RST_PD_DATA 32'h0000_0000
// ****************************************
// fixed capability fields and eeprom base address
// ****************************************
`define LTV_PD_CAP_ID 8'h03
`define LTV_PD_NEXT_PTR 8'hf0
`define LTV_MSI_CAP_ID 8'h05
`define LTV_MSI_NEXT_PTR 8'h00
`define LTV_PD_EE_BASE 9'h040
// ****************************************
// field positions and wait decode constants
// ****************************************
`define LTV_F_L0S_LSB 8
`define LTV_F_L1_LSB 16
`define LTV_F_WAIT_LSB 24
`define LTV_F_PD_ADDR_LSB 18
`define LTV_F_PD_FLAG 31
`define LTV_WAIT_OFFSET_MS 9'd128
`define LTV_WAIT_HALF 8'h80
// ****************************************
// fast training set symbols
// ****************************************
`define LTV_SYM_K28_5 8'hbc
`define LTV_SYM_K28_1 8'h3c
// ****************************************
// interrupt status bits
// ****************************************
`define LTV_IRQ_RD_DONE 0
`define LTV_IRQ_WR_DONE 1
`endif
